// file: design/status_flag_pkg.sv
// Address map, field layout and reset values of the status and flag bank
package status_flag_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CHAN_N = 4;
  localparam int NIB_W = 4;

  localparam logic [7:0] STATUS_RESERVED_ADDR = 8'h01;
  localparam logic [7:0] STATUS_INDICATORS_ADDR = 8'h02;
  localparam logic [7:0] SIGNAL_LOSS_ADDR = 8'h03;
  localparam logic [7:0] TRANSMIT_FAULT_ADDR = 8'h04;
  localparam logic [7:0] CHANNEL_STATUS_RESERVED_ADDR = 8'h05;
  localparam logic [7:0] TEMPERATURE_ADDR = 8'h06;
  localparam logic [7:0] SUPPLY_VOLTAGE_ADDR = 8'h07;
  localparam logic [7:0] MODULE_MONITOR_RESERVED_ADDR = 8'h08;
  localparam logic [7:0] RX_POWER_CH1_CH2_ADDR = 8'h09;
  localparam logic [7:0] RX_POWER_CH3_CH4_ADDR = 8'h0a;
  localparam logic [7:0] TX_BIAS_CH1_CH2_ADDR = 8'h0b;
  localparam logic [7:0] TX_BIAS_CH3_CH4_ADDR = 8'h0c;
  localparam logic [7:0] TX_POWER_CH1_CH2_ADDR = 8'h0d;
  localparam logic [7:0] TX_POWER_CH3_CH4_ADDR = 8'h0e;

  // Flag storage spans the implemented part of the flag field
  localparam int FLAG_FIRST = 3;
  localparam int FLAG_LAST = 14;

  // Status byte 2 fields
  localparam int INTERRUPT_LEVEL_BIT = 1;
  localparam int DATA_NOT_READY_BIT = 0;

  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] RESERVED_VALUE = 8'h00;
  localparam logic DATA_NOT_READY_RESET = 1'b1;

  // Implemented bits per flag byte, bytes 3 to 14 in order
  localparam logic [7:0] FLAG_MASK [FLAG_FIRST:FLAG_LAST] = '{
    8'h0f, 8'h0f, 8'h00, 8'hf0, 8'hf0, 8'h00,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff
  };
endpackage : status_flag_pkg

// file: design/module_status_flag_bank.sv
// Status bytes and latched flag bytes of the transceiver management map
//
// Notes on behaviour
// - Status byte 2 bit 1 always shows the interrupt output pin level.
// - Status byte 2 bit 0 reads high until monitor data is ready.
// - Bytes 3 to 21 form the flag field of alarms and warnings.
// - Every flag bit is zero after reset and in normal operation.
// - A defined fault, alarm or warning condition sets its flag bit.
// - A set flag stays set until a host read of its byte clears it.
// - Asserting the module reset pin clears all latched flags.
// - Byte 3 bits 3..0 hold latched receive signal loss, channels 4..1.
// - Byte 3 bits 7..4, transmit signal loss, are unsupported and read zero.
// - Byte 4 bits 3..0 hold latched transmit faults; bits 7..4 reserved.
// - Byte 6 bits 7..4 hold temperature high/low alarm, high/low warning.
// - Byte 7 bits 7..4 hold supply voltage alarms and warnings likewise.
// - Bytes 9,10 hold receive power flags, odd channels in upper nibble.
// - Bytes 11,12 hold transmit bias flags in the same nibble layout.
// - Bytes 13,14 hold transmit power flags in the same nibble layout.
// - The host reads every status and flag byte over the serial link.
`timescale 1ns/100ps
module module_status_flag_bank
(
  input logic sys_clk,
  input logic rst_n,
  input logic module_reset_n,
  input logic interrupt_request_n,
  input logic monitor_data_ready,
  input logic [3:0] rx_signal_loss,
  input logic [3:0] transmit_fault,
  input logic [3:0] temperature_cond,
  input logic [3:0] supply_voltage_cond,
  input logic [15:0] rx_power_cond,
  input logic [15:0] tx_bias_cond,
  input logic [15:0] tx_power_cond,
  input logic link_clk,
  input logic link_rst_n,
  input logic link_rd_req,
  input logic [7:0] link_rd_addr,
  output logic link_rd_busy,
  output logic link_rd_valid,
  output logic [7:0] link_rd_data
);

  // Link domain: request capture and answer return
  logic req_toggle;
  logic next_req_toggle;
  logic [7:0] addr_hold;
  logic [7:0] next_addr_hold;
  logic ack_meta;
  logic ack_sync;
  logic ack_seen;
  logic next_busy;
  logic next_valid;
  logic [7:0] next_rd_data;
  logic ack_edge;

  // System domain: request detection, flags and answer
  logic req_meta;
  logic req_sync;
  logic req_seen;
  logic reset_meta;
  logic reset_sync;
  logic ack_toggle;
  logic next_ack_toggle;
  logic [7:0] ack_data;
  logic [7:0] next_ack_data;
  logic data_not_ready;
  logic next_data_not_ready;
  logic [7:0] flags [status_flag_pkg::FLAG_FIRST:status_flag_pkg::FLAG_LAST];
  logic [7:0] next_flags [status_flag_pkg::FLAG_FIRST:status_flag_pkg::FLAG_LAST];
  logic [7:0] cond [status_flag_pkg::FLAG_FIRST:status_flag_pkg::FLAG_LAST];
  logic serve;
  logic [7:0] read_byte;

  // The address is held until the answer returns, so the system side
  // may sample it directly once the request toggle has crossed.
  assign ack_edge = ack_sync ^ ack_seen;

  always_comb
  begin
    next_req_toggle = req_toggle;
    next_addr_hold = addr_hold;
    next_busy = link_rd_busy;
    next_valid = 1'b0;
    next_rd_data = link_rd_data;
    if (ack_edge)
    begin
      next_busy = 1'b0;
      next_valid = 1'b1;
      next_rd_data = ack_data;
    end
    // Requests made while one is outstanding are dropped
    else if (link_rd_req && !link_rd_busy)
    begin
      next_req_toggle = ~req_toggle;
      next_addr_hold = link_rd_addr;
      next_busy = 1'b1;
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      req_toggle <= 1'b0;
      addr_hold <= status_flag_pkg::RESERVED_VALUE;
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
      ack_seen <= 1'b0;
      link_rd_busy <= 1'b0;
      link_rd_valid <= 1'b0;
      link_rd_data <= status_flag_pkg::RESERVED_VALUE;
    end
    else
    begin
      req_toggle <= next_req_toggle;
      addr_hold <= next_addr_hold;
      ack_meta <= ack_toggle;
      ack_sync <= ack_meta;
      ack_seen <= ack_sync;
      link_rd_busy <= next_busy;
      link_rd_valid <= next_valid;
      link_rd_data <= next_rd_data;
    end
  end

  // System side
  assign serve = req_sync ^ req_seen;

  always_comb
  begin
    for (int i = status_flag_pkg::FLAG_FIRST; i <= status_flag_pkg::FLAG_LAST; i++)
    begin
      cond[i] = status_flag_pkg::FLAG_RESET;
    end
    cond[status_flag_pkg::SIGNAL_LOSS_ADDR] = {4'h0, rx_signal_loss};
    cond[status_flag_pkg::TRANSMIT_FAULT_ADDR] = {4'h0, transmit_fault};
    cond[status_flag_pkg::TEMPERATURE_ADDR] = {temperature_cond, 4'h0};
    cond[status_flag_pkg::SUPPLY_VOLTAGE_ADDR] = {supply_voltage_cond, 4'h0};
    cond[status_flag_pkg::RX_POWER_CH1_CH2_ADDR] = {rx_power_cond[3:0], rx_power_cond[7:4]};
    cond[status_flag_pkg::RX_POWER_CH3_CH4_ADDR] = {rx_power_cond[11:8], rx_power_cond[15:12]};
    cond[status_flag_pkg::TX_BIAS_CH1_CH2_ADDR] = {tx_bias_cond[3:0], tx_bias_cond[7:4]};
    cond[status_flag_pkg::TX_BIAS_CH3_CH4_ADDR] = {tx_bias_cond[11:8], tx_bias_cond[15:12]};
    cond[status_flag_pkg::TX_POWER_CH1_CH2_ADDR] = {tx_power_cond[3:0], tx_power_cond[7:4]};
    cond[status_flag_pkg::TX_POWER_CH3_CH4_ADDR] = {tx_power_cond[11:8], tx_power_cond[15:12]};
  end

  always_comb
  begin
    for (int i = status_flag_pkg::FLAG_FIRST; i <= status_flag_pkg::FLAG_LAST; i++)
    begin
      // A condition present in the clearing cycle wins over the clear
      if (serve && addr_hold == 8'(i))
      begin
        next_flags[i] = cond[i] & status_flag_pkg::FLAG_MASK[i];
      end
      else
      begin
        next_flags[i] = (flags[i] | cond[i]) & status_flag_pkg::FLAG_MASK[i];
      end
      if (!reset_sync)
      begin
        next_flags[i] = status_flag_pkg::FLAG_RESET;
      end
    end
  end

  always_comb
  begin
    next_data_not_ready = data_not_ready;
    if (!reset_sync)
    begin
      next_data_not_ready = status_flag_pkg::DATA_NOT_READY_RESET;
    end
    else if (monitor_data_ready)
    begin
      next_data_not_ready = 1'b0;
    end
  end

  always_comb
  begin
    read_byte = status_flag_pkg::RESERVED_VALUE;
    if (addr_hold == status_flag_pkg::STATUS_INDICATORS_ADDR)
    begin
      read_byte[status_flag_pkg::INTERRUPT_LEVEL_BIT] = interrupt_request_n;
      read_byte[status_flag_pkg::DATA_NOT_READY_BIT] = data_not_ready;
    end
    else if (addr_hold >= 8'(status_flag_pkg::FLAG_FIRST) &&
             addr_hold <= 8'(status_flag_pkg::FLAG_LAST))
    begin
      // masked storage keeps unsupported bits zero
      read_byte = flags[addr_hold];
    end
  end

  always_comb
  begin
    next_ack_toggle = ack_toggle;
    next_ack_data = ack_data;
    if (serve)
    begin
      next_ack_toggle = ~ack_toggle;
      next_ack_data = read_byte;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      req_seen <= 1'b0;
      reset_meta <= 1'b0;
      reset_sync <= 1'b0;
      ack_toggle <= 1'b0;
      ack_data <= status_flag_pkg::RESERVED_VALUE;
      data_not_ready <= status_flag_pkg::DATA_NOT_READY_RESET;
      for (int i = status_flag_pkg::FLAG_FIRST; i <= status_flag_pkg::FLAG_LAST; i++)
      begin
        flags[i] <= status_flag_pkg::FLAG_RESET;
      end
    end
    else
    begin
      req_meta <= req_toggle;
      req_sync <= req_meta;
      req_seen <= req_sync;
      reset_meta <= module_reset_n;
      reset_sync <= reset_meta;
      ack_toggle <= next_ack_toggle;
      ack_data <= next_ack_data;
      data_not_ready <= next_data_not_ready;
      for (int i = status_flag_pkg::FLAG_FIRST; i <= status_flag_pkg::FLAG_LAST; i++)
      begin
        flags[i] <= next_flags[i];
      end
    end
  end

  default clocking sys_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  interrupt_request_n_mirror_a: assert property (
    (serve && addr_hold == status_flag_pkg::STATUS_INDICATORS_ADDR)
      |=> ack_data[status_flag_pkg::INTERRUPT_LEVEL_BIT] == $past(interrupt_request_n))
    else $error("interrupt level bit does not follow the pin");

  data_ready_a: assert property (
    (reset_sync && reset_meta && monitor_data_ready) |=> !data_not_ready [*2])
    else $error("data not ready bit failed to fall");

  reset_clear_a: assert property (
    !reset_sync |=> (flags[3] == 8'h00 && flags[9] == 8'h00 && flags[14] == 8'h00))
    else $error("module reset left a flag set");

  flag_set_a: assert property (
    (reset_sync && rx_signal_loss[0]) |=> flags[3][0])
    else $error("signal loss condition did not set its flag");

  latch_hold_a: assert property (
    (flags[13][7] && reset_sync
      && !(serve && addr_hold == status_flag_pkg::TX_POWER_CH1_CH2_ADDR))
      |=> flags[13][7] || !$past(reset_sync))
    else $error("latched flag dropped without a read");

  read_clear_a: assert property (
    (serve && addr_hold == status_flag_pkg::SIGNAL_LOSS_ADDR && reset_sync
      && rx_signal_loss == 4'h0) |=> flags[3] == 8'h00)
    else $error("read did not clear its flag byte");

  reassert_flag_a: assert property (
    (serve && addr_hold == status_flag_pkg::TRANSMIT_FAULT_ADDR && reset_sync
      && transmit_fault[2]) |=> flags[4][2])
    else $error("persisting condition lost at clearing read");

  tx_loss_zero_a: assert property (
    (serve && addr_hold == status_flag_pkg::SIGNAL_LOSS_ADDR) |=> ack_data[7:4] == 4'h0)
    else $error("unsupported transmit loss bits read nonzero");

  reserved_zero_a: assert property (
    (serve && (addr_hold == status_flag_pkg::STATUS_RESERVED_ADDR
      || addr_hold == status_flag_pkg::CHANNEL_STATUS_RESERVED_ADDR
      || addr_hold == status_flag_pkg::MODULE_MONITOR_RESERVED_ADDR)) |=> ack_data == 8'h00)
    else $error("reserved byte read nonzero");

  nibble_read_a: assert property (
    (serve && addr_hold == status_flag_pkg::RX_POWER_CH1_CH2_ADDR)
      |=> ack_data == $past(flags[9]))
    else $error("receive power byte answer mismatches stored flags");

  rx_loss_order_a: assert property (
    (reset_sync && rx_signal_loss[3]) |=> flags[3][3])
    else $error("channel 4 signal loss landed on the wrong bit");

  fault_order_a: assert property (
    (reset_sync && transmit_fault[3]) |=> flags[4][3])
    else $error("channel 4 transmit fault landed on the wrong bit");

  temp_order_a: assert property (
    (reset_sync && temperature_cond[3]) |=> flags[6][7])
    else $error("temperature high alarm landed on the wrong bit");

  supply_order_a: assert property (
    (reset_sync && supply_voltage_cond[0]) |=> flags[7][4])
    else $error("supply low warning landed on the wrong bit");

  bias_nibble_a: assert property (
    (reset_sync && tx_bias_cond[0]) |=> flags[11][4])
    else $error("channel 1 bias low warning landed on the wrong bit");

  power_nibble_a: assert property (
    (reset_sync && tx_power_cond[15]) |=> flags[14][3])
    else $error("channel 4 power high alarm landed on the wrong bit");

  unused_zero_a: assert property (
    flags[3][7:4] == 4'h0 && flags[4][7:4] == 4'h0 && flags[6][3:0] == 4'h0)
    else $error("unsupported or reserved flag bit set");

  not_ready_reset_a: assert property (
    !reset_sync |=> data_not_ready)
    else $error("module reset did not raise data not ready");

  read_set_flag_c: cover property (
    serve && addr_hold == status_flag_pkg::SIGNAL_LOSS_ADDR && flags[3] != 8'h00);
  module_reset_c: cover property (flags[6] != 8'h00 ##1 !reset_sync);
  data_ready_c: cover property (data_not_ready ##1 !data_not_ready);
  reread_held_c: cover property (
    serve && addr_hold == status_flag_pkg::SIGNAL_LOSS_ADDR && rx_signal_loss != 4'h0);
  status_low_c: cover property (
    serve && addr_hold == status_flag_pkg::STATUS_INDICATORS_ADDR && !interrupt_request_n);

endmodule : module_status_flag_bank

// file: test/host_reader.sv
// Host controller model that fetches single bytes through the link read port
`timescale 1ns/100ps
module host_reader
(
  input wire logic link_clk,
  input wire logic link_rd_busy,
  input wire logic link_rd_valid,
  input wire logic [7:0] link_rd_data,
  output logic link_rd_req,
  output logic [7:0] link_rd_addr
);
  initial
  begin
    link_rd_req = 1'b0;
    link_rd_addr = 8'h00;
  end

  task automatic read_byte(input logic [7:0] addr, output logic [7:0] data, output bit ok);
    int i;
    ok = 1'b0;
    data = 8'h00;
    for (i = 0; i < 12 && link_rd_busy !== 1'b0; i++)
      @(negedge link_clk);
    @(negedge link_clk);
    link_rd_req = 1'b1;
    link_rd_addr = addr;
    @(posedge link_clk);
    @(negedge link_clk);
    link_rd_req = 1'b0;
    // Released address shows its inverse so a stale value cannot pass
    link_rd_addr = ~addr;
    // Sampled mid-cycle, clear of the edge that launches the answer
    for (i = 0; i < 12 && !ok; i++)
    begin
      @(negedge link_clk);
      if (link_rd_valid === 1'b1)
      begin
        data = link_rd_data;
        ok = 1'b1;
      end
    end
  endtask : read_byte
endmodule : host_reader

// file: test/module_status_flag_bank_bench.sv
// Self-checking bench for the status and latched flag bank
`timescale 1ns/100ps
`define CHECK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module module_status_flag_bank_bench;
  logic sys_clk, rst_n, module_reset_n, interrupt_request_n, monitor_data_ready;
  logic [3:0] rx_signal_loss, transmit_fault, temperature_cond, supply_voltage_cond;
  logic [15:0] rx_power_cond, tx_bias_cond, tx_power_cond;
  logic link_clk, link_rst_n, link_rd_req, link_rd_busy, link_rd_valid;
  logic [7:0] link_rd_addr, link_rd_data;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  // Distinct nibble per channel exposes any swapped channel or nibble order
  localparam logic [63:0] PATTERN_A = 64'h5a96_4321_8765_cba9;
  localparam logic [7:0] EXP_A [3:14] = '{8'h05, 8'h0a, 8'h00, 8'h90, 8'h60, 8'h00,
    8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc};

  module_status_flag_bank i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .module_reset_n(module_reset_n), .interrupt_request_n(interrupt_request_n),
    .monitor_data_ready(monitor_data_ready), .rx_signal_loss(rx_signal_loss),
    .transmit_fault(transmit_fault), .temperature_cond(temperature_cond),
    .supply_voltage_cond(supply_voltage_cond), .rx_power_cond(rx_power_cond),
    .tx_bias_cond(tx_bias_cond), .tx_power_cond(tx_power_cond), .link_clk(link_clk),
    .link_rst_n(link_rst_n), .link_rd_req(link_rd_req), .link_rd_addr(link_rd_addr),
    .link_rd_busy(link_rd_busy), .link_rd_valid(link_rd_valid),
    .link_rd_data(link_rd_data));

  host_reader i_host (.link_clk(link_clk), .link_rd_busy(link_rd_busy),
    .link_rd_valid(link_rd_valid), .link_rd_data(link_rd_data),
    .link_rd_req(link_rd_req), .link_rd_addr(link_rd_addr));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Link clock phase offset keeps link edges off the sys_clk edges
  initial
  begin
    link_clk = 1'b0;
    #7.3;
    forever #15 link_clk = ~link_clk;
  end

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      $display("Error at %0t: run did not finish", $time);
      give_verdict();
    end
  end

  task automatic set_conds(input logic [63:0] v);
    {rx_signal_loss, transmit_fault, temperature_cond, supply_voltage_cond,
      rx_power_cond, tx_bias_cond, tx_power_cond} = v;
  endtask : set_conds

  task automatic pulse_conds(input logic [63:0] v);
    @(negedge sys_clk);
    set_conds(v);
    @(negedge sys_clk);
    set_conds(64'h0);
  endtask : pulse_conds

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    bit ok;
    i_host.read_byte(a, d, ok);
    if (!ok)
    begin
      n_errors++;
      $display("Error at %0t: no answer for %h", $time, a);
    end
    `CHECK(d, e)
    `CHECK(link_rd_busy, 1'b0)
    @(negedge link_clk);
    `CHECK(link_rd_valid, 1'b0)
  endtask : rd_chk

  task automatic test_reset_values();
    for (int a = 0; a <= 15; a++)
      rd_chk(a[7:0], (a == 2) ? 8'h03 : 8'h00);
    rd_chk(8'hff, 8'h00);
    $display("test reset_values done");
  endtask : test_reset_values

  task automatic test_status();
    @(negedge sys_clk);
    interrupt_request_n = 1'b0;
    monitor_data_ready = 1'b1;
    rd_chk(8'h02, 8'h00);
    @(negedge sys_clk);
    interrupt_request_n = 1'b1;
    rd_chk(8'h02, 8'h02);
    $display("test status done");
  endtask : test_status

  task automatic test_flags(input logic [63:0] v, input logic [7:0] exp [3:14]);
    pulse_conds(v);
    for (int a = 3; a <= 14; a++)
      rd_chk(a[7:0], exp[a]);
    for (int a = 3; a <= 14; a++)
      rd_chk(a[7:0], 8'h00);
    $display("test flags done");
  endtask : test_flags

  task automatic test_sticky();
    @(negedge sys_clk);
    rx_signal_loss = 4'h8;
    transmit_fault = 4'h4;
    rd_chk(8'h03, 8'h08);
    rd_chk(8'h03, 8'h08);
    rd_chk(8'h04, 8'h04);
    @(negedge sys_clk);
    rx_signal_loss = 4'h0;
    transmit_fault = 4'h0;
    rd_chk(8'h03, 8'h08);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h04, 8'h04);
    rd_chk(8'h04, 8'h00);
    $display("test sticky done");
  endtask : test_sticky

  task automatic test_module_reset();
    pulse_conds(64'hffff_ffff_ffff_ffff);
    @(negedge sys_clk);
    module_reset_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    module_reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    for (int a = 3; a <= 14; a++)
      rd_chk(a[7:0], 8'h00);
    $display("test module_reset done");
  endtask : test_module_reset

  initial
  begin
    rst_n = 1'b0;
    link_rst_n = 1'b0;
    module_reset_n = 1'b1;
    interrupt_request_n = 1'b1;
    monitor_data_ready = 1'b0;
    set_conds(64'h0);
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge link_clk);
    link_rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    test_reset_values();
    test_status();
    test_flags(PATTERN_A, EXP_A);
    test_flags(64'hffff_ffff_ffff_ffff, status_flag_pkg::FLAG_MASK);
    test_sticky();
    test_module_reset();
    give_verdict();
  end
endmodule : module_status_flag_bank_bench
